// ==== acp_pkg.sv ====
package acp_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ACP_REG_FMT = 8'h1B;
    localparam logic [7:0] ACP_REG_OFFSET = 8'h1C;
    localparam logic [7:0] ACP_REG_POL = 8'h1D;
    localparam logic [7:0] ACP_REG_BDIV = 8'h1E;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACP_FMT_RST = 8'h00;
    localparam logic [7:0] ACP_OFFSET_RST = 8'h00;
    localparam logic [7:0] ACP_POL_RST = 8'h00;
    localparam logic [7:0] ACP_BDIV_RST = 8'h01;

    // ------------------------------------------------------------
    // field positions, format register
    // ------------------------------------------------------------
    localparam int ACP_FMT_MODE_HI = 7;
    localparam int ACP_FMT_MODE_LO = 6;
    localparam int ACP_FMT_WIDTH_HI = 5;
    localparam int ACP_FMT_WIDTH_LO = 4;
    localparam int ACP_FMT_BCLK_MST = 3;
    localparam int ACP_FMT_WCLK_MST = 2;
    localparam int ACP_FMT_TDM = 1;
    localparam int ACP_FMT_TRISTATE = 0;

    // ------------------------------------------------------------
    // field positions, polarity and clocking register
    // ------------------------------------------------------------
    localparam int ACP_POL_PLL_EN = 7;
    localparam int ACP_POL_PLL_CODEC = 6;
    localparam int ACP_POL_REF_HI = 5;
    localparam int ACP_POL_REF_LO = 4;
    localparam int ACP_POL_BCLK_INV = 3;
    localparam int ACP_POL_WCLK_PULSE = 2;
    localparam int ACP_POL_CONT = 1;
    localparam int ACP_POL_CLKOUT = 0;

    // ------------------------------------------------------------
    // modes and selections
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ACP_MODE_I2S = 2'h0,
        ACP_MODE_DSP = 2'h1,
        ACP_MODE_RJ = 2'h2,
        ACP_MODE_LJ = 2'h3
    } acp_mode_t;

    typedef enum logic [1:0]
    {
        ACP_REF_MCLK = 2'h0,
        ACP_REF_BCLK = 2'h1,
        ACP_REF_GPI = 2'h2
    } acp_ref_t;

    localparam logic [5:0] ACP_WORD_BITS = 6'h20;
    localparam logic [4:0] ACP_WORD_MSB = 5'h1F;
    localparam logic [9:0] ACP_I2S_DELAY = 10'h001;
    localparam logic [7:0] ACP_BDIV_MIN = 8'h02;

    function automatic logic [5:0] acp_width_bits(input logic [1:0] code);
        case (code)
            2'h0: acp_width_bits = 6'h10;
            2'h1: acp_width_bits = 6'h14;
            2'h2: acp_width_bits = 6'h18;
            default: acp_width_bits = 6'h20;
        endcase
    endfunction

    function automatic logic acp_in_slot(input logic [9:0] idx, input logic [9:0] start, input logic [5:0] w);
        acp_in_slot = (idx >= start) && (idx < start + 10'(w));
    endfunction

    function automatic logic [4:0] acp_slot_pos(input logic [9:0] idx, input logic [9:0] start);
        logic [9:0] diff;
        diff = idx - start;
        acp_slot_pos = diff[4:0];
    endfunction

endpackage

// ==== acp_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module acp_pin_sync
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic [2:0] sh_q;
    logic lvl_q;
    logic agree;

    // the first stage feeds only the second; a change counts once stages two and three agree
    assign agree = (sh_q[2] == sh_q[1]);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sh_q <= '0;
            lvl_q <= 1'b0;
        end
        else
        begin
            sh_q <= {sh_q[1:0], pin};
            if (agree)
                lvl_q <= sh_q[1];
        end
    end

    // newest settled value, so a level read at another pin's edge is not one sample late
    assign level = agree ? sh_q[1] : lvl_q;
    assign rise = agree && sh_q[1] && !lvl_q;
    assign fall = agree && !sh_q[1] && lvl_q;

endmodule

`default_nettype wire

// ==== acp_serial_port.sv ====
// Overview of operation
// - The port frames data as left-justified, right-justified, I2S, DSP or TDM, with PCM carried in TDM.
// - Words go MSB first and are 16, 20, 24 or 32 bits long as chosen by bits 5:4 of the format register.
// - Word clock and bit clock are each independently driven by the device or taken from the far party.
// - The word clock marks frame start and is either a one-bit pulse or a square wave.
// - The word clock rate is the higher of the ADC and DAC sample rates.
// - A master bit clock comes from a divider in the bit clock divider register.
// - The first data bit is delayed from frame start by the bit count in the data offset register.
// - Bit 3 of the polarity register swaps the bit clock edges used for data in every mode.
// - With bit 0 of the format register set the data output floats on every bit without valid data.
// - A master interface that is powered down floats all of its pins.
// - Generated bit and word clocks run only while the ADC or DAC is powered or the continuous bit is set, and idle otherwise; clock out does not stop.
// - A continuous option keeps generated clocks running while the codec is powered down.
// - The reference clock is chosen from the master clock, bit clock or general purpose input pin.
// - An optional fractional multiplier makes the internal master clock.
// - The generated master clock can be driven out on a pin.
// - Internal clocks may come straight from the reference while the multiplier feeds only the output pin.
`timescale 1ns/1ps
`default_nettype none

module acp_serial_port
    import acp_pkg::*;
#(
    parameter logic [15:0] PLL_STEP = 16'h4000
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic mclk_pin,
    input wire logic general_purpose_input_pin,
    input wire logic bclk_in,
    output logic bclk_out,
    output logic bclk_oe,
    input wire logic wclk_in,
    output logic wclk_out,
    output logic wclk_oe,
    input wire logic din_pin,
    output logic dout_out,
    output logic dout_oe,
    output logic clkout_out,
    output logic clkout_oe,
    input wire logic adc_pwr,
    input wire logic dac_pwr,
    input wire logic iface_pwr,
    input wire logic [9:0] adc_frame_div,
    input wire logic [9:0] dac_frame_div,
    input wire logic [31:0] adc_left,
    input wire logic [31:0] adc_right,
    output logic adc_taken,
    output logic [31:0] dac_left,
    output logic [31:0] dac_right,
    output logic dac_valid
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic mclk_rise, gpi_rise, bclk_lvl, bclk_rise, bclk_fall, wclk_lvl, din_lvl;

    acp_pin_sync u_mclk (.clk_sys(clk_sys), .reset_n(reset_n), .pin(mclk_pin),
        .level(), .rise(mclk_rise), .fall());
    acp_pin_sync u_gpi (.clk_sys(clk_sys), .reset_n(reset_n), .pin(general_purpose_input_pin),
        .level(), .rise(gpi_rise), .fall());
    acp_pin_sync u_bclk (.clk_sys(clk_sys), .reset_n(reset_n), .pin(bclk_in),
        .level(bclk_lvl), .rise(bclk_rise), .fall(bclk_fall));
    acp_pin_sync u_wclk (.clk_sys(clk_sys), .reset_n(reset_n), .pin(wclk_in),
        .level(wclk_lvl), .rise(), .fall());
    acp_pin_sync u_din (.clk_sys(clk_sys), .reset_n(reset_n), .pin(din_pin),
        .level(din_lvl), .rise(), .fall());

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] fmt_q, offs_q, pol_q, bdiv_q, rdata_q;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            fmt_q <= ACP_FMT_RST;
            offs_q <= ACP_OFFSET_RST;
            pol_q <= ACP_POL_RST;
            bdiv_q <= ACP_BDIV_RST;
        end
        else if (reg_wr_en)
        begin
            case (reg_addr)
                ACP_REG_FMT: fmt_q <= reg_wdata;
                ACP_REG_OFFSET: offs_q <= reg_wdata;
                ACP_REG_POL: pol_q <= reg_wdata;
                ACP_REG_BDIV: bdiv_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            rdata_q <= '0;
        else if (reg_rd_en)
        begin
            case (reg_addr)
                ACP_REG_FMT: rdata_q <= fmt_q;
                ACP_REG_OFFSET: rdata_q <= offs_q;
                ACP_REG_POL: rdata_q <= pol_q;
                ACP_REG_BDIV: rdata_q <= bdiv_q;
                default: rdata_q <= '0;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    acp_mode_t mode;
    acp_ref_t ref_sel;
    logic [5:0] width;
    logic bclk_mst, wclk_mst, tdm, tri_en, pll_en, pll_codec, inv, pulse, cont, clkout_en;

    assign mode = acp_mode_t'(fmt_q[ACP_FMT_MODE_HI:ACP_FMT_MODE_LO]);
    assign width = acp_width_bits(fmt_q[ACP_FMT_WIDTH_HI:ACP_FMT_WIDTH_LO]);
    assign bclk_mst = fmt_q[ACP_FMT_BCLK_MST];
    assign wclk_mst = fmt_q[ACP_FMT_WCLK_MST];
    assign tdm = fmt_q[ACP_FMT_TDM];
    assign tri_en = fmt_q[ACP_FMT_TRISTATE];
    assign pll_en = pol_q[ACP_POL_PLL_EN];
    assign pll_codec = pol_q[ACP_POL_PLL_CODEC];
    assign ref_sel = acp_ref_t'(pol_q[ACP_POL_REF_HI:ACP_POL_REF_LO]);
    assign inv = pol_q[ACP_POL_BCLK_INV];
    assign pulse = pol_q[ACP_POL_WCLK_PULSE];
    assign cont = pol_q[ACP_POL_CONT];
    assign clkout_en = pol_q[ACP_POL_CLKOUT];

    // ------------------------------------------------------------
    // reference clock, multiplier and clock out
    // ------------------------------------------------------------
    logic ref_tick, pll_lock_q, pll_tick, codec_tick, clkout_q;
    logic [15:0] acc_q;
    logic [16:0] acc_sum;

    always_comb
    begin
        case (ref_sel)
            ACP_REF_MCLK: ref_tick = mclk_rise;
            ACP_REF_BCLK: ref_tick = bclk_rise;
            ACP_REF_GPI: ref_tick = gpi_rise;
            default: ref_tick = 1'b0;
        endcase
    end

    // fractional phase accumulator; only starts once the reference has been seen
    assign acc_sum = {1'b0, acc_q} + {1'b0, PLL_STEP};
    assign pll_tick = pll_lock_q && acc_sum[16];

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !pll_en)
        begin
            pll_lock_q <= 1'b0;
            acc_q <= '0;
        end
        else
        begin
            if (ref_tick)
                pll_lock_q <= 1'b1;
            if (pll_lock_q)
                acc_q <= acc_sum[15:0];
        end
    end

    // clock out always follows the multiplier, so the codec may run straight off the reference
    assign codec_tick = pll_codec ? pll_tick : ref_tick;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            clkout_q <= 1'b0;
        else if (pll_tick)
            clkout_q <= !clkout_q;
    end

    assign clkout_out = clkout_q;
    assign clkout_oe = clkout_en;

    // ------------------------------------------------------------
    // master frame and bit clock generation
    // ------------------------------------------------------------
    logic running, frame_wrap, m_frame, m_launch, m_capture, tick_run;
    logic [9:0] frame_len, frame_cnt_q, frame_cnt_d;
    logic [7:0] n_div, bdiv_cnt_q;
    logic bclk_q, wclk_q, frame_pend_q;

    assign running = adc_pwr || dac_pwr || cont;
    assign tick_run = codec_tick && running;
    assign frame_len = (adc_frame_div < dac_frame_div) ? adc_frame_div : dac_frame_div;
    assign frame_wrap = (frame_cnt_q >= frame_len - 10'h001);
    assign frame_cnt_d = frame_wrap ? '0 : frame_cnt_q + 10'h001;
    assign n_div = (bdiv_q < ACP_BDIV_MIN) ? ACP_BDIV_MIN : bdiv_q;
    assign m_frame = tick_run && frame_wrap;
    assign m_launch = tick_run && (frame_wrap || bdiv_cnt_q == n_div - 8'h01);
    assign m_capture = tick_run && !m_launch && (bdiv_cnt_q == (n_div >> 1) - 8'h01);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            frame_cnt_q <= '0;
            bdiv_cnt_q <= '0;
        end
        else if (tick_run)
        begin
            frame_cnt_q <= frame_cnt_d;
            // the divider restarts with each frame so bit 0 lines up with the word clock
            bdiv_cnt_q <= m_launch ? '0 : bdiv_cnt_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // edge events and frame detection
    // ------------------------------------------------------------
    logic launch_ev, capture_ev, first_lvl, pend, wclk_next, wclk_now, wprev_q;
    logic frame_ev, half_ev;

    assign launch_ev = bclk_mst ? m_launch : (inv ? bclk_rise : bclk_fall);
    assign capture_ev = bclk_mst ? m_capture : (inv ? bclk_fall : bclk_rise);
    assign first_lvl = (mode != ACP_MODE_I2S) || tdm;
    assign pend = frame_pend_q || m_frame;
    assign wclk_next = pulse ? (pend ? first_lvl : !first_lvl)
                             : ((frame_cnt_q < (frame_len >> 1)) ? first_lvl : !first_lvl);
    assign wclk_now = wclk_mst ? wclk_next : wclk_lvl;
    assign frame_ev = launch_ev && (wclk_now != wprev_q) && (wclk_now == first_lvl);
    assign half_ev = launch_ev && (wclk_now != wprev_q) && (wclk_now != first_lvl);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            bclk_q <= 1'b0;
            wclk_q <= 1'b0;
            wprev_q <= 1'b0;
            frame_pend_q <= 1'b0;
        end
        else
        begin
            if (!running)
                bclk_q <= inv;
            else if (m_launch)
                bclk_q <= inv;
            else if (m_capture)
                bclk_q <= !inv;
            if (launch_ev)
            begin
                wclk_q <= wclk_next;
                wprev_q <= wclk_now;
                frame_pend_q <= 1'b0;
            end
            else if (m_frame)
                frame_pend_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // slot placement and data transfer
    // ------------------------------------------------------------
    logic [9:0] bit_idx_q, half_q, bit_n, dly, rj_adj, left_start, right_start;
    logic [31:0] tx_l_q, tx_r_q, rx_sh_q, rx_next, dac_l_q, dac_r_q;
    logic in_left, in_right, slot_valid_q, slot_right_q, dout_q, taken_q, dvalid_q;
    logic [4:0] slot_pos_q, pos_n;
    logic dsp_like;

    assign dsp_like = (mode == ACP_MODE_DSP) || tdm;
    assign dly = (mode == ACP_MODE_I2S && !tdm) ? ACP_I2S_DELAY : '0;
    assign rj_adj = (mode == ACP_MODE_RJ && !tdm) ? half_q - 10'(width) : '0;
    assign left_start = 10'(offs_q) + dly + rj_adj;
    assign right_start = dsp_like ? left_start + 10'(width) : left_start + half_q;
    assign bit_n = frame_ev ? '0 : ((bit_idx_q == '1) ? bit_idx_q : bit_idx_q + 10'h001);
    assign in_left = acp_in_slot(bit_n, left_start, width);
    assign in_right = !in_left && acp_in_slot(bit_n, right_start, width);
    assign pos_n = in_left ? acp_slot_pos(bit_n, left_start) : acp_slot_pos(bit_n, right_start);
    assign rx_next = {rx_sh_q[30:0], din_lvl};

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            bit_idx_q <= '1;
            half_q <= '0;
            slot_valid_q <= 1'b0;
            slot_right_q <= 1'b0;
            slot_pos_q <= '0;
            dout_q <= 1'b0;
            tx_l_q <= '0;
            tx_r_q <= '0;
            taken_q <= 1'b0;
        end
        else
        begin
            taken_q <= 1'b0;
            if (launch_ev)
            begin
                // saturate so a missing word clock never wraps into a false slot
                if (frame_ev || bit_idx_q != '1)
                    bit_idx_q <= bit_n;
                if (half_ev)
                    half_q <= bit_n;
                slot_valid_q <= in_left || in_right;
                slot_right_q <= in_right;
                slot_pos_q <= pos_n;
                if (frame_ev)
                begin
                    tx_l_q <= adc_left;
                    tx_r_q <= adc_right;
                    taken_q <= 1'b1;
                    dout_q <= in_left ? adc_left[ACP_WORD_MSB - pos_n] : 1'b0;
                end
                else if (in_left)
                    dout_q <= tx_l_q[ACP_WORD_MSB - pos_n];
                else if (in_right)
                    dout_q <= tx_r_q[ACP_WORD_MSB - pos_n];
                else
                    dout_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            rx_sh_q <= '0;
            dac_l_q <= '0;
            dac_r_q <= '0;
            dvalid_q <= 1'b0;
        end
        else
        begin
            dvalid_q <= 1'b0;
            if (capture_ev && slot_valid_q)
            begin
                rx_sh_q <= rx_next;
                if (slot_pos_q == 5'(width - 6'h01))
                begin
                    if (slot_right_q)
                    begin
                        dac_r_q <= rx_next << (ACP_WORD_BITS - width);
                        dvalid_q <= 1'b1;
                    end
                    else
                        dac_l_q <= rx_next << (ACP_WORD_BITS - width);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign bclk_out = bclk_q;
    assign wclk_out = wclk_q;
    assign bclk_oe = bclk_mst && iface_pwr;
    assign wclk_oe = wclk_mst && iface_pwr;
    assign dout_out = dout_q;
    assign dout_oe = iface_pwr && (slot_valid_q || !tri_en);
    assign adc_taken = taken_q;
    assign dac_left = dac_l_q;
    assign dac_right = dac_r_q;
    assign dac_valid = dvalid_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_launch_msb;
        launch_ev && (in_left || in_right) && pos_n == '0 && !frame_ev;
    endsequence

    sequence s_gated;
        !running && bclk_mst ##1 !running;
    endsequence

    a_bclk_idle_gate: assert property (s_gated |-> bclk_q == $past(inv))
        else $error("bit clock toggles while codec clocks are gated");
    a_cont_clock_run: assert property (cont && codec_tick && frame_len > 10'h001 |=> frame_cnt_q != $past(frame_cnt_q))
        else $error("continuous clocking did not advance the frame");
    a_pins_hiz_down: assert property (!iface_pwr |-> !bclk_oe && !wclk_oe && !dout_oe)
        else $error("interface pins driven while powered down");
    a_tri_gap_float: assert property (launch_ev && tri_en && !in_left && !in_right ##1 !launch_ev |-> !dout_oe)
        else $error("data output driven outside a valid slot");
    a_msb_first_out: assert property (s_launch_msb |=> dout_q == (slot_right_q ? tx_r_q[ACP_WORD_MSB] : tx_l_q[ACP_WORD_MSB]))
        else $error("first bit of a word is not its msb");
    a_frame_bit_zero: assert property (frame_ev |=> bit_idx_q == '0 && taken_q)
        else $error("frame start did not restart the bit count");
    a_offset_slot_start: assert property (launch_ev && bit_n == left_start && width != '0 |=> slot_valid_q && !slot_right_q)
        else $error("first data bit not placed at the programmed offset");
    a_launch_polarity: assert property (bclk_mst && m_launch ##1 !m_capture |-> bclk_q == inv)
        else $error("bit clock launch edge has wrong polarity");
    a_rate_max_fs: assert property (m_frame |-> frame_len <= adc_frame_div && frame_len <= dac_frame_div)
        else $error("word clock not at the higher sample rate");

endmodule

`default_nettype wire

// ==== acp_far_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module acp_far_host
#(
    parameter int HALF_NS = 800
)
(
    input wire logic run,
    input wire logic [31:0] tx_l,
    input wire logic [31:0] tx_r,
    input wire logic dout,
    input wire logic dout_oe,
    output logic bclk,
    output logic wclk,
    output logic din,
    output logic [31:0] rx_l,
    output logic [31:0] rx_r,
    output logic oe_outside,
    output int nfr
);
    logic [31:0] w;
    logic oe_seen;
    int pos;

    // ------------------------------------------------------------
    // slave-mode frame source, left-justified, 16-bit slots
    // ------------------------------------------------------------
    initial
    begin
        bclk = 1'b0;
        wclk = 1'b0;
        din = 1'b0;
        rx_l = 32'h0;
        rx_r = 32'h0;
        oe_outside = 1'b0;
        nfr = 0;
        forever
        begin
            wait (run);
            for (int i = 0; i < 64; i++)
            begin
                w = (i < 32) ? tx_l : tx_r;
                pos = i % 32;
                wclk = (i < 32);
                // outside a slot the line shows no stale value
                din = (pos < 16) ? w[31 - pos] : ~din;
                if (i == 0)
                    oe_seen = 1'b0;
                #(HALF_NS);
                bclk = 1'b1;
                if (pos < 16 && i < 32)
                    rx_l[31 - pos] = dout;
                if (pos < 16 && i >= 32)
                    rx_r[31 - pos] = dout;
                if (pos >= 16 && dout_oe)
                    oe_seen = 1'b1;
                #(HALF_NS);
                bclk = 1'b0;
            end
            // bclk stands still low between runs; result published per finished frame
            oe_outside = oe_seen;
            nfr++;
        end
    end
endmodule

`default_nettype wire

// ==== test_acp_serial_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_acp_serial_port
    import acp_pkg::*;
;
    localparam logic [31:0] TX_L = 32'hC3A51234, TX_R = 32'h5A3C9876;
    localparam logic [31:0] ADC_L = 32'h9ABC0000, ADC_R = 32'h3F810000;
    logic clk_sys, reset_n, reg_wr_en, reg_rd_en, mclk_pin, adc_pwr, dac_pwr, iface_pwr, run;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic bclk, wclk, din, bclk_out, bclk_oe, wclk_out, wclk_oe, dout_out, dout_oe, oe_outside;
    logic clkout_out, clkout_oe, dac_valid;
    logic [31:0] dac_left, dac_right, rx_l, rx_r;
    int n_mismatch = 0;
    int comparisons = 0;
    int nfr, nb, nw;
    int nck = 0;
    int ndv = 0;

    acp_serial_port u_acp_serial_port (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mclk_pin(mclk_pin), .general_purpose_input_pin(1'b0), .bclk_in(bclk), .bclk_out(bclk_out),
        .bclk_oe(bclk_oe), .wclk_in(wclk), .wclk_out(wclk_out), .wclk_oe(wclk_oe), .din_pin(din),
        .dout_out(dout_out), .dout_oe(dout_oe), .clkout_out(clkout_out), .clkout_oe(clkout_oe), .adc_pwr(adc_pwr),
        .dac_pwr(dac_pwr), .iface_pwr(iface_pwr), .adc_frame_div(10'h040), .dac_frame_div(10'h080),
        .adc_left(ADC_L), .adc_right(ADC_R), .adc_taken(), .dac_left(dac_left), .dac_right(dac_right),
        .dac_valid(dac_valid));

    acp_far_host u_acp_far_host (.run(run), .tx_l(TX_L), .tx_r(TX_R), .dout(dout_out), .dout_oe(dout_oe),
        .bclk(bclk), .wclk(wclk), .din(din), .rx_l(rx_l), .rx_r(rx_r), .oe_outside(oe_outside), .nfr(nfr));

    // ------------------------------------------------------------
    // clocks and tasks
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial
    begin
        mclk_pin = 1'b0;
        forever #200 mclk_pin = ~mclk_pin;
    end

    always @(posedge clkout_out)
        nck++;

    always @(posedge clk_sys)
        if (dac_valid === 1'b1)
            ndv++;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
    endtask

    // counts bit clock changes and word clock rises over 2560 cycles
    task automatic win(output int b, output int f);
        logic pb, pw;
        b = 0;
        f = 0;
        pb = bclk_out;
        pw = wclk_out;
        repeat (2560)
        begin
            @(negedge clk_sys);
            if (bclk_out !== pb)
                b++;
            if (wclk_out === 1'b1 && pw === 1'b0)
                f++;
            pb = bclk_out;
            pw = wclk_out;
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #5000000;
        n_mismatch++;
        print_verdict;
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        {reset_n, reg_wr_en, reg_rd_en, adc_pwr, dac_pwr, iface_pwr, run} = 7'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        rd_chk(ACP_REG_FMT, ACP_FMT_RST);
        rd_chk(ACP_REG_OFFSET, ACP_OFFSET_RST);
        rd_chk(ACP_REG_POL, ACP_POL_RST);
        rd_chk(ACP_REG_BDIV, ACP_BDIV_RST);
        wr(ACP_REG_OFFSET, 8'hA5);
        rd_chk(ACP_REG_OFFSET, 8'hA5);
        wr(ACP_REG_OFFSET, 8'h00);
        wr(8'h1F, 8'h77);
        rd_chk(8'h1F, 8'h00);
        wr(ACP_REG_FMT, 8'hC1);
        {adc_pwr, dac_pwr, iface_pwr, run} = 4'hF;
        wait (nfr == 4);
        run = 1'b0;
        chk("dac_left", {TX_L[31:16], 16'h0}, {dac_left[31:16], 16'h0});
        chk("dac_right", {TX_R[31:16], 16'h0}, {dac_right[31:16], 16'h0});
        chk("dout_left", ADC_L, rx_l);
        chk("dout_right", ADC_R, rx_r);
        chk("oe_outside", 32'h0, {31'h0, oe_outside});
        chk("dac_valid", 32'(nfr), 32'(ndv));
        @(negedge clk_sys);
        {adc_pwr, dac_pwr} = 2'b00;
        wr(ACP_REG_BDIV, 8'h04);
        wr(ACP_REG_FMT, 8'h0C);
        win(nb, nw);
        win(nb, nw);
        chk("bclk_idle", 32'h0, 32'(nb));
        chk("clock_oe", 32'h3, {30'h0, bclk_oe, wclk_oe});
        wr(ACP_REG_POL, 8'h02);
        win(nb, nw);
        chk("bclk_bits", 32'h1, 32'(nb >= 300 && nb <= 340));
        chk("wclk_rate", 32'h1, 32'(nw >= 9 && nw <= 11));
        wr(ACP_REG_POL, 8'h00);
        adc_pwr = 1'b1;
        win(nb, nw);
        chk("bclk_run", 32'h1, 32'(nb > 0));
        @(negedge clk_sys);
        iface_pwr = 1'b0;
        @(negedge clk_sys);
        chk("pins_float", 32'h0, {29'h0, bclk_oe, wclk_oe, dout_oe});
        wr(ACP_REG_POL, 8'h81);
        win(nb, nw);
        chk("clkout_oe", 32'h1, {31'h0, clkout_oe});
        chk("clkout_run", 32'h1, 32'(nck >= 300 && nck <= 340));
        print_verdict;
    end
endmodule

`default_nettype wire
